// ==== design/boot_inquiry_selection_handler.sv ====
`timescale 1ns/1ps
module boot_inquiry_selection_handler #(
  parameter logic [31:0] DEV_CODE = 32'h4456_3031 // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             erase_req,
  input  wire logic        erase_done,
  output logic             prog_state,
  output logic [31:0]      device_code,
  output logic             device_selected,
  output logic [7:0]       clock_mode,
  output logic             mode_selected,
  output logic             other_valid,
  output logic [7:0]       other_cmd
);
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_ERASE} state_e;
  typedef enum logic [1:0] {TX_ACK, TX_ERR, TX_ROM, TX_STAT} txkind_e;

  frame_if fr ();

  state_e     state;
  txkind_e    tx_kind;
  logic [7:0] rsp_cmd;
  logic [7:0] hdr;
  logic [7:0] err_code;
  logic [7:0] tx_pos;
  logic [7:0] tx_acc;
  logic [7:0] last_err;

  logic       accept;
  logic       allowed;
  logic [7:0] rom_cmd;
  logic [7:0] rom_idx;
  logic       rom_known;
  logic [7:0] rom_code;
  logic [7:0] rom_len;
  logic [7:0] rom_byte;
  logic       dev_match;
  logic       mode_ok;

  logic       next_send;
  logic       next_erase;
  txkind_e    next_kind;
  logic [7:0] next_hdr;
  logic [7:0] next_err;
  logic       next_dev_store;
  logic       next_mode_store;
  logic       next_other;

  logic [7:0] pay_len;
  logic [7:0] total;
  logic [7:0] next_byte;
  logic       load;

  frame_rx u_frame_rx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_ready (rx_ready),
    .fr       (fr.rx)
  );

  // The ROM looks at the live frame while deciding, then the held command
  assign rom_cmd = (state == S_IDLE) ? fr.cmd : rsp_cmd;
  assign rom_idx = tx_pos - 8'h02;

  resp_rom #(
    .DEV_CODE (DEV_CODE)
  ) u_resp_rom (
    .cmd       (rom_cmd),
    .idx       (rom_idx),
    .sel_code  (fr.payload),
    .sel_mode  (fr.payload[7:0]),
    .known     (rom_known),
    .rsp_code  (rom_code),
    .rsp_len   (rom_len),
    .rsp_byte  (rom_byte),
    .dev_match (dev_match),
    .mode_ok   (mode_ok)
  );

  assign accept  = fr.valid && (state == S_IDLE);
  assign allowed = !prog_state || (fr.cmd == boot_pkg::CMD_STATUS);
  assign fr.take = accept;

  // Decide the reply for a complete frame
  always_comb begin
    next_send       = 1'b0;
    next_erase      = 1'b0;
    next_kind       = TX_ACK;
    next_hdr        = boot_pkg::RSP_ACK;
    next_err        = boot_pkg::ERC_NONE;
    next_dev_store  = 1'b0;
    next_mode_store = 1'b0;
    next_other      = 1'b0;
    if (accept) begin
      if (!allowed) begin
        next_other = 1'b1;
      end else begin
        case (fr.cmd)
          boot_pkg::CMD_DEV_SEL: begin
            next_send = 1'b1;
            if (!fr.sum_ok) begin
              next_kind = TX_ERR;
              next_hdr  = boot_pkg::RSP_ERR_DEV;
              next_err  = boot_pkg::ERC_SUM;
            end else if (fr.size != boot_pkg::DEV_SEL_SIZE ||
                         !dev_match) begin
              next_kind = TX_ERR;
              next_hdr  = boot_pkg::RSP_ERR_DEV;
              next_err  = boot_pkg::ERC_DEV;
            end else begin
              next_dev_store = 1'b1;
            end
          end
          boot_pkg::CMD_MODE_SEL: begin
            next_send = 1'b1;
            if (!fr.sum_ok) begin
              next_kind = TX_ERR;
              next_hdr  = boot_pkg::RSP_ERR_MODE;
              next_err  = boot_pkg::ERC_SUM;
            end else if (fr.size != boot_pkg::MODE_SEL_SIZE ||
                         !mode_ok) begin
              next_kind = TX_ERR;
              next_hdr  = boot_pkg::RSP_ERR_MODE;
              next_err  = boot_pkg::ERC_MODE;
            end else begin
              next_mode_store = 1'b1;
            end
          end
          boot_pkg::CMD_STATUS: begin
            next_send = 1'b1;
            next_kind = TX_STAT;
            next_hdr  = boot_pkg::RSP_STATUS;
          end
          boot_pkg::CMD_TO_PROG: begin
            next_erase = 1'b1;
          end
          default: begin
            if (rom_known) begin
              next_send = 1'b1;
              next_kind = TX_ROM;
              next_hdr  = rom_code;
            end else begin
              // Bit-rate selection and unknown codes go to outside logic
              next_other = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Byte stream of the reply: code, size, payload, checksum; an ACK is the code alone, an error reply the code and the error code
  always_comb begin
    pay_len   = (tx_kind == TX_STAT) ? boot_pkg::STAT_LEN : rom_len;
    total     = pay_len + boot_pkg::FRAME_EXTRA;
    next_byte = hdr;
    case (tx_kind)
      TX_ACK: begin
        total = boot_pkg::ACK_TOTAL;
      end
      TX_ERR: begin
        total = boot_pkg::ERR_TOTAL;
        if (tx_pos != 8'h00) begin
          next_byte = err_code;
        end
      end
      default: begin
        if (tx_pos == 8'h01) begin
          next_byte = pay_len;
        end else if (tx_pos == pay_len + 8'h02) begin
          next_byte = 8'h00 - tx_acc;
        end else if (tx_pos != 8'h00) begin
          if (tx_kind == TX_ROM) begin
            next_byte = rom_byte;
          end else if (rom_idx == 8'h00) begin
            next_byte = prog_state ? boot_pkg::STAT_PROG
                                   : boot_pkg::STAT_SELECT;
          end else begin
            next_byte = last_err;
          end
        end
      end
    endcase
  end

  assign load = (state == S_SEND) && (!tx_valid || tx_ready);

  // Sequencing and transmit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_IDLE;
      tx_kind  <= TX_ACK;
      rsp_cmd  <= 8'h00;
      hdr      <= 8'h00;
      err_code <= 8'h00;
      tx_pos   <= 8'h00;
      tx_acc   <= 8'h00;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          tx_pos <= 8'h00;
          tx_acc <= 8'h00;
          if (next_send) begin
            state    <= S_SEND;
            tx_kind  <= next_kind;
            hdr      <= next_hdr;
            err_code <= next_err;
            rsp_cmd  <= fr.cmd;
          end else if (next_erase) begin
            state <= S_ERASE;
          end
        end
        S_ERASE: begin
          // Acknowledged only once the erase is finished
          if (erase_done) begin
            state   <= S_SEND;
            tx_kind <= TX_ACK;
            hdr     <= boot_pkg::RSP_ACK;
          end
        end
        S_SEND: begin
          if (load) begin
            if (tx_pos < total) begin
              tx_data  <= next_byte;
              tx_valid <= 1'b1;
              tx_acc   <= tx_acc + next_byte;
              tx_pos   <= tx_pos + 8'h01;
            end else begin
              tx_valid <= 1'b0;
              state    <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign erase_req = (state == S_ERASE);

  // Selections; a newer one simply overwrites the older
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_code     <= 32'h0000_0000;
      device_selected <= 1'b0;
      clock_mode      <= 8'h00;
      mode_selected   <= 1'b0;
    end else begin
      if (next_dev_store) begin
        device_code     <= fr.payload;
        device_selected <= 1'b1;
      end
      if (next_mode_store) begin
        clock_mode    <= fr.payload[7:0];
        mode_selected <= 1'b1;
      end
    end
  end

  // Boot state and last error for the status reply
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_state <= 1'b0;
      last_err   <= 8'h00;
    end else begin
      if (state == S_ERASE && erase_done) begin
        prog_state <= 1'b1;
      end
      if (accept && next_send && next_kind != TX_STAT) begin
        last_err <= next_err;
      end
    end
  end

  // Handed-off commands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      other_valid <= 1'b0;
      other_cmd   <= 8'h00;
    end else begin
      other_valid <= next_other;
      if (next_other) begin
        other_cmd <= fr.cmd;
      end
    end
  end
endmodule

// ==== design/boot_pkg.sv ====
package boot_pkg;
  // Command codes accepted from the host
  localparam logic [7:0] CMD_DEV_INQ   = 8'h20;
  localparam logic [7:0] CMD_DEV_SEL   = 8'h10;
  localparam logic [7:0] CMD_MODE_INQ  = 8'h21;
  localparam logic [7:0] CMD_MODE_SEL  = 8'h11;
  localparam logic [7:0] CMD_RATIO_INQ = 8'h22;
  localparam logic [7:0] CMD_FREQ_INQ  = 8'h23;
  localparam logic [7:0] CMD_MEM_INQ   = 8'h25;
  localparam logic [7:0] CMD_BLK_INQ   = 8'h26;
  localparam logic [7:0] CMD_UNIT_INQ  = 8'h27;
  localparam logic [7:0] CMD_NEW_RATE  = 8'h3F;
  localparam logic [7:0] CMD_TO_PROG   = 8'h40;
  localparam logic [7:0] CMD_STATUS    = 8'h4F;
  // Response codes
  localparam logic [7:0] RSP_DEV       = 8'h30;
  localparam logic [7:0] RSP_MODE      = 8'h31;
  localparam logic [7:0] RSP_RATIO     = 8'h32;
  localparam logic [7:0] RSP_FREQ      = 8'h33;
  localparam logic [7:0] RSP_MEM       = 8'h35;
  localparam logic [7:0] RSP_BLK       = 8'h36;
  localparam logic [7:0] RSP_UNIT      = 8'h37;
  localparam logic [7:0] RSP_STATUS    = 8'h5F;
  localparam logic [7:0] RSP_ACK       = 8'h06;
  localparam logic [7:0] RSP_ERR_DEV   = 8'h90;
  localparam logic [7:0] RSP_ERR_MODE  = 8'h91;
  // Error codes
  localparam logic [7:0] ERC_NONE      = 8'h00;
  localparam logic [7:0] ERC_SUM       = 8'h11;
  localparam logic [7:0] ERC_DEV       = 8'h21;
  localparam logic [7:0] ERC_MODE      = 8'h22;
  // Boot status codes
  localparam logic [7:0] STAT_SELECT   = 8'h11;
  localparam logic [7:0] STAT_ERASE    = 8'h1E;
  localparam logic [7:0] STAT_PROG     = 8'h1F;
  // Fixed sizes
  localparam logic [7:0] DEV_SEL_SIZE  = 8'h04;
  localparam logic [7:0] MODE_SEL_SIZE = 8'h01;
  localparam logic [7:0] STAT_LEN      = 8'h02;
  localparam logic [7:0] ERR_TOTAL     = 8'h02;
  localparam logic [7:0] ACK_TOTAL     = 8'h01;
  localparam logic [7:0] FRAME_EXTRA   = 8'h03;
  localparam logic [1:0] CODE_BYTES    = 2'h3;
endpackage

// ==== design/frame_if.sv ====
`timescale 1ns/1ps
interface frame_if;
  logic        valid;
  logic        take;
  logic [7:0]  cmd;
  logic [7:0]  size;
  logic [31:0] payload;
  logic        sum_ok;

  modport rx (output valid, output cmd, output size, output payload,
              output sum_ok, input take);
  modport proc (input valid, input cmd, input size, input payload,
                input sum_ok, output take);
endinterface

// ==== design/resp_rom.sv ====
`timescale 1ns/1ps
module resp_rom #(
  parameter logic [31:0] DEV_CODE = 32'h4456_3031 // Arbitrary value
) (
  input  wire logic [7:0]  cmd,
  input  wire logic [7:0]  idx,
  input  wire logic [31:0] sel_code,
  input  wire logic [7:0]  sel_mode,
  output logic             known,
  output logic [7:0]       rsp_code,
  output logic [7:0]       rsp_len,
  output logic [7:0]       rsp_byte,
  output logic             dev_match,
  output logic             mode_ok
);
  localparam int ROM_LEN   = 57;
  localparam int MODE_CNT  = 2;
  localparam int MODE_LIST = 11;
  localparam logic [7:0] DEV_OFS = 8'h00, DEV_LEN = 8'h0A;
  localparam logic [7:0] MOD_OFS = 8'h0A, MOD_LEN = 8'h03;
  localparam logic [7:0] RAT_OFS = 8'h0D, RAT_LEN = 8'h07;
  localparam logic [7:0] FRQ_OFS = 8'h14, FRQ_LEN = 8'h09;
  localparam logic [7:0] MEM_OFS = 8'h1D, MEM_LEN = 8'h09;
  localparam logic [7:0] BLK_OFS = 8'h26, BLK_LEN = 8'h11;
  localparam logic [7:0] UNI_OFS = 8'h37, UNI_LEN = 8'h02;
  // Payloads only; code, size and checksum are added by the sender
  localparam logic [0:ROM_LEN-1][7:0] ROM = {
    8'h01, 8'h08, DEV_CODE, 8'h42, 8'h54, 8'h4C, 8'h44,
    8'h02, 8'h01, 8'h02,
    8'h02, 8'h02, 8'h04, 8'h02, 8'h02, 8'h02, 8'hFE,
    8'h02, 8'h07, 8'hD0, 8'h13, 8'h88, 8'h03, 8'hE8, 8'h13, 8'h88,
    8'h01, 32'h0000_0000, 32'h0007_FFFF,
    8'h02, 32'h0000_0000, 32'h0000_FFFF, 32'h0001_0000, 32'h0007_FFFF,
    8'h00, 8'h80};

  logic [7:0]          ofs;
  logic [7:0]          addr;
  logic [MODE_CNT-1:0] hit;

  always_comb begin
    known    = 1'b1;
    ofs      = DEV_OFS;
    rsp_len  = DEV_LEN;
    rsp_code = boot_pkg::RSP_DEV;
    case (cmd)
      boot_pkg::CMD_DEV_INQ: begin
        ofs      = DEV_OFS;
      end
      boot_pkg::CMD_MODE_INQ: begin
        ofs      = MOD_OFS;
        rsp_len  = MOD_LEN;
        rsp_code = boot_pkg::RSP_MODE;
      end
      boot_pkg::CMD_RATIO_INQ: begin
        ofs      = RAT_OFS;
        rsp_len  = RAT_LEN;
        rsp_code = boot_pkg::RSP_RATIO;
      end
      boot_pkg::CMD_FREQ_INQ: begin
        ofs      = FRQ_OFS;
        rsp_len  = FRQ_LEN;
        rsp_code = boot_pkg::RSP_FREQ;
      end
      boot_pkg::CMD_MEM_INQ: begin
        ofs      = MEM_OFS;
        rsp_len  = MEM_LEN;
        rsp_code = boot_pkg::RSP_MEM;
      end
      boot_pkg::CMD_BLK_INQ: begin
        ofs      = BLK_OFS;
        rsp_len  = BLK_LEN;
        rsp_code = boot_pkg::RSP_BLK;
      end
      boot_pkg::CMD_UNIT_INQ: begin
        ofs      = UNI_OFS;
        rsp_len  = UNI_LEN;
        rsp_code = boot_pkg::RSP_UNIT;
      end
      default: known = 1'b0;
    endcase
    addr     = ofs + idx;
    rsp_byte = (int'(addr) < ROM_LEN) ? ROM[addr] : 8'h00;
  end

  // Mode bytes are plain mode numbers, compared as sent
  for (genvar i = 0; i < MODE_CNT; i++) begin : g_mode
    assign hit[i] = (ROM[MODE_LIST + i] == sel_mode);
  end

  assign mode_ok   = |hit;
  assign dev_match = (sel_code == DEV_CODE);
endmodule

// ==== design/frame_rx.sv ====
`timescale 1ns/1ps
module frame_rx (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  frame_if.rx             fr
);
  typedef enum logic [2:0] {F_CMD, F_SIZE, F_DATA, F_SUM, F_HOLD} fstate_e;

  fstate_e    state;
  logic [7:0] sum;
  logic [7:0] left;
  logic [2:0] got;
  logic       framed;

  assign framed   = (rx_data == boot_pkg::CMD_DEV_SEL) ||
                    (rx_data == boot_pkg::CMD_MODE_SEL) ||
                    (rx_data == boot_pkg::CMD_NEW_RATE);
  // Stall the link while the previous frame is being answered
  assign rx_ready = (state != F_HOLD);
  assign fr.valid = (state == F_HOLD);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= F_CMD;
      sum        <= 8'h00;
      left       <= 8'h00;
      got        <= 3'h0;
      fr.cmd     <= 8'h00;
      fr.size    <= 8'h00;
      fr.payload <= 32'h0000_0000;
      fr.sum_ok  <= 1'b0;
    end else if (state == F_HOLD) begin
      if (fr.take) begin
        state <= F_CMD;
      end
    end else if (rx_valid) begin
      case (state)
        F_CMD: begin
          fr.cmd     <= rx_data;
          fr.size    <= 8'h00;
          fr.payload <= 32'h0000_0000;
          sum        <= rx_data;
          got        <= 3'h0;
          fr.sum_ok  <= 1'b1;
          state      <= framed ? F_SIZE : F_HOLD;
        end
        F_SIZE: begin
          fr.size <= rx_data;
          left    <= rx_data;
          sum     <= sum + rx_data;
          state   <= (rx_data == 8'h00) ? F_SUM : F_DATA;
        end
        F_DATA: begin
          // Only the first four payload bytes are kept
          if (got <= {1'b0, boot_pkg::CODE_BYTES}) begin
            fr.payload <= {fr.payload[23:0], rx_data};
            got        <= got + 3'h1;
          end
          sum   <= sum + rx_data;
          left  <= left - 8'h01;
          state <= (left == 8'h01) ? F_SUM : F_DATA;
        end
        F_SUM: begin
          fr.sum_ok <= ((sum + rx_data) == 8'h00);
          state     <= F_HOLD;
        end
        default: state <= F_CMD;
      endcase
    end
  end
endmodule

// ==== bench/boot_assertions.sv ====
`timescale 1ns/1ps
module boot_checker #(
  parameter logic [31:0] DEV_CODE = 32'h4456_3031
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_ready,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic        erase_req,
  input wire logic        erase_done,
  input wire logic        prog_state,
  input wire logic [31:0] device_code,
  input wire logic        device_selected,
  input wire logic [7:0]  clock_mode,
  input wire logic        mode_selected,
  input wire logic        other_valid,
  input wire logic [7:0]  other_cmd
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_tx_byte_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped before taken");
  a_dev_code_match: assert property (
    device_selected |-> device_code == DEV_CODE)
    else $error("stored device code differs");
  a_mode_supported: assert property (
    mode_selected |-> clock_mode == 8'h01 || clock_mode == 8'h02)
    else $error("stored clock mode unsupported");
  a_erase_wait: assert property (
    erase_req && !erase_done |=> erase_req)
    else $error("erase request dropped early");
  a_prog_after_erase: assert property (
    $rose(prog_state) |-> !erase_req &&
    ($past(erase_req) || $past(erase_req, 2)))
    else $error("programming state without erase");
  a_ack_after_erase: assert property (
    $fell(erase_req) |-> ##[0:4] (tx_valid && tx_data == 8'h06))
    else $error("no acknowledge after erase");
  a_prog_frozen: assert property (
    prog_state |=> prog_state && $stable(device_code) &&
    $stable(clock_mode))
    else $error("selection changed in programming state");
  a_other_pulse: assert property (
    other_valid |=> !other_valid)
    else $error("other_valid longer than one cycle");
endmodule

bind boot_inquiry_selection_handler boot_checker #(.DEV_CODE(DEV_CODE))
  chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .erase_req(erase_req),
  .erase_done(erase_done), .prog_state(prog_state),
  .device_code(device_code), .device_selected(device_selected),
  .clock_mode(clock_mode), .mode_selected(mode_selected),
  .other_valid(other_valid), .other_cmd(other_cmd));

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       slow,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;

  initial tx_ready = 1'b1;

  // Slow host takes one cycle in four, so replies must wait
  always @(posedge core_clk) begin
    if (rst_n && tx_valid && tx_ready) got.push_back(tx_data);
    ph = ph + 2'h1;
    #1;
    tx_ready = !slow || ph == 2'h3;
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [7:0]   c;
    int           ni;
    logic [31:0]  pi;
    logic         bad;
    logic [7:0]   r;
    int           n;
    logic [135:0] p;
  } row_s;
  localparam logic [31:0] DEV = 32'h5A31_3243; // Arbitrary value
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        erase_done = 1'b0;
  logic        slow = 1'b0;
  logic        rx_ready, tx_valid, tx_ready, erase_req, prog_state;
  logic        device_selected, mode_selected, other_valid;
  logic [7:0]  tx_data, clock_mode, other_cmd;
  logic [31:0] device_code;
  logic [7:0]  e[$];
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  row_s        rows [18] = '{
    '{8'h10, 4, 32'h0, 1'b0, 8'h90, 1, 136'h21},
    '{8'h4F, 0, 32'h0, 1'b0, 8'h5F, 2, 136'h1121},
    '{8'h10, 4, DEV, 1'b1, 8'h90, 1, 136'h11},
    '{8'h10, 4, DEV, 1'b0, 8'h06, 0, 136'h0},
    '{8'h4F, 0, 32'h0, 1'b0, 8'h5F, 2, 136'h1100},
    '{8'h11, 1, 32'h03, 1'b0, 8'h91, 1, 136'h22},
    '{8'h11, 1, 32'h01, 1'b1, 8'h91, 1, 136'h11},
    '{8'h11, 1, 32'h01, 1'b0, 8'h06, 0, 136'h0},
    '{8'h11, 1, 32'h02, 1'b0, 8'h06, 0, 136'h0},
    '{8'h20, 0, 32'h0, 1'b0, 8'h30, 10,
      {16'h0108, DEV, 32'h4254_4C44}},
    '{8'h21, 0, 32'h0, 1'b0, 8'h31, 3, 136'h020102},
    '{8'h22, 0, 32'h0, 1'b0, 8'h32, 7, 136'h02020402_0202FE},
    '{8'h23, 0, 32'h0, 1'b0, 8'h33, 9,
      136'h02_07D0_1388_03E8_1388},
    '{8'h25, 0, 32'h0, 1'b0, 8'h35, 9, 136'h01_0000_0000_0007_FFFF},
    '{8'h26, 0, 32'h0, 1'b0, 8'h36, 17,
      136'h02_0000_0000_0000_FFFF_0001_0000_0007_FFFF},
    '{8'h27, 0, 32'h0, 1'b0, 8'h37, 2, 136'h0080},
    '{8'h4F, 0, 32'h0, 1'b0, 8'h5F, 2, 136'h1F00},
    '{8'h40, 0, 32'h0, 1'b0, 8'h06, 0, 136'h0}};

  always #10 core_clk = ~core_clk;

  boot_inquiry_selection_handler #(.DEV_CODE(DEV)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .erase_req(erase_req),
    .erase_done(erase_done), .prog_state(prog_state),
    .device_code(device_code), .device_selected(device_selected),
    .clock_mode(clock_mode), .mode_selected(mode_selected),
    .other_valid(other_valid), .other_cmd(other_cmd));

  host_model host_u (
    .core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .slow(slow), .tx_ready(tx_ready));

  always @(posedge core_clk) erase_done <= erase_req & ~erase_done;

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] c, input int ni,
                      input logic [31:0] pi, input logic bad);
    logic [7:0] b[$];
    logic [7:0] s;
    b = {c};
    if (ni > 0) begin
      b.push_back(ni[7:0]);
      for (int k = ni - 1; k >= 0; k--) b.push_back(pi[8*k +: 8]);
      s = 8'h00;
      foreach (b[j]) s -= b[j];
      b.push_back(s + bad);
    end
    // Valid stays low across one edge between frames
    @(posedge core_clk);
    #1;
    rx_valid = 1'b1;
    foreach (b[j]) begin
      rx_data = b[j];
      do @(negedge core_clk); while (rx_ready !== 1'b1);
      @(posedge core_clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask

  task automatic tx_row(input int i);
    send(rows[i].c, rows[i].ni, rows[i].pi, rows[i].bad);
  endtask

  task automatic chk_row(input int i);
    logic [7:0] s;
    logic       fr;
    fr = !(rows[i].r inside {8'h06, 8'h90, 8'h91});
    e = {rows[i].r};
    if (fr) e.push_back(rows[i].n[7:0]);
    for (int k = rows[i].n - 1; k >= 0; k--) e.push_back(rows[i].p[8*k +: 8]);
    s = 8'h00;
    foreach (e[j]) s -= e[j];
    if (fr) e.push_back(s);
    foreach (e[j]) begin
      for (int w = 0; w < 400 && host_u.got.size() == 0; w++)
        @(negedge core_clk);
      check("reply byte", host_u.got.size() > 0 ?
            host_u.got.pop_front() : 32'hDEAD, e[j]);
    end
  endtask

  task automatic quiet();
    repeat (20) @(negedge core_clk);
    check("no reply", host_u.got.size(), 32'h0);
  endtask

  task automatic wait_other(input logic [7:0] c);
    for (int w = 0; w < 100 && other_valid !== 1'b1; w++)
      @(negedge core_clk);
    check("other frame", {other_valid, other_cmd}, {1'b1, c});
    quiet();
  endtask

  task automatic flags(input logic [6:0] x);
    check("flags", {rx_ready, tx_valid, erase_req, prog_state,
          device_selected, mode_selected, other_valid}, x);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    flags(7'b1000000);
    for (int i = 0; i < 16; i++) begin
      tx_row(i);
      chk_row(i);
    end
    check("device_code", device_code, DEV);
    check("clock_mode", clock_mode, 8'h02);
    flags(7'b1000110);
    slow = 1'b1;
    tx_row(11);
    chk_row(11);
    slow = 1'b0;
    tx_row(10);
    tx_row(15);
    chk_row(10);
    chk_row(15);
    send(8'h3F, 4, 32'h00C0_07D0, 1'b0);
    wait_other(8'h3F);
    tx_row(17);
    for (int w = 0; w < 50 && erase_req !== 1'b1; w++)
      @(negedge core_clk);
    check("prog while erasing", {erase_req, prog_state}, 2'h2);
    chk_row(17);
    check("prog_state", prog_state, 1'b1);
    tx_row(9);
    wait_other(8'h20);
    tx_row(16);
    chk_row(16);
    @(posedge core_clk);
    #1;
    rst_n = 1'b0;
    #1;
    flags(7'b1000000);
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tx_row(4);
    chk_row(4);
    end_sim();
  end
endmodule
